// ---- rtl/ssp_defs.svh ----
/*
  register offsets, reset values and timing counts of the serial port block.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

`define SSP_ADDR_W        8
`define SSP_DATA_W        32
`define SSP_BYTE_W        8
`define SSP_FIFO_DEPTH    32
`define SSP_OFS_CTRL      8'he0
`define SSP_OFS_DATA      8'he4
`define SSP_OFS_STAT      8'he8
`define SSP_CTRL_RST      8'h00
`define SSP_STAT_PAD      2'h0
`define SSP_SHIFT_RST     8'h00
`define SSP_TX_FILL       8'hff
`define SSP_CNT_LAST      3'h7
`define SSP_CNT_ZERO      3'h0
`define SSP_CNT_ONE       3'h1
`define SSP_RESP_OKAY     2'h0
`define SSP_RESP_DECERR   2'h3
`define SSP_SCK_HALF_NS   40
`define SSP_CLK_NS        10
`define SSP_SCK_HALF_CYC  ((`SSP_SCK_HALF_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_PRE_W         4

`endif

// ---- rtl/ssp_pkg.sv ----
/*
  types of the serial port block: control layout, status layout, states.
  assumes the constants header is on the include path.
*/
`include "ssp_defs.svh"

package ssp_pkg;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic clk_ext;
    logic lsb_first;
    logic tx_rx;
    logic edge_rise;
    logic start;
    logic shift_en;
    logic int_en;
    logic pend;
  } ssp_ctrl_t;

  // status register, bit 7 down to bit 0
  typedef struct packed {
    logic       busy;
    logic       tx_full;
    logic       tx_empty;
    logic [1:0] pad;
    logic [2:0] cnt;
  } ssp_stat_t;

  typedef enum logic {
    st_idle,
    st_shift
  } ssp_state_t;

endpackage : ssp_pkg

// ---- rtl/ssp_fifo.sv ----
/*
  first-in first-out buffer with registered read data, valid/ready both sides.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_fifo
  import ssp_pkg::*;
#(
  parameter int WIDTH = `SSP_BYTE_W,
  parameter int DEPTH = `SSP_FIFO_DEPTH
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW-1:0]    rd_d;
  logic [PW:0]      cnt_q;
  logic [PW:0]      cnt_d;
  logic             push;
  logic             pop;

  // full refuses the writer, so back-pressure reaches the bus
  assign in_ready = (cnt_q < (PW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign rd_d     = pop ? rd_q + 1'b1 : rd_q;
  assign cnt_d    = cnt_q + (PW+1)'(push) - (PW+1)'(pop);

  // storage has no reset; the pointers, fill level and output register do
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // head word out of a register; bypass when the write lands on the head
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end else begin
      out_data  <= (push && wr_q == rd_d) ? in_data : mem_q[rd_d];
      out_valid <= (cnt_d != '0);
    end
  end

endmodule : ssp_fifo

// ---- rtl/ssp_core.sv ----
/*
  synchronous serial port: axi4-lite control/status, tx byte fifo, 8-bit shifter.
  assumes pins are asynchronous to aclk; a single aclk with synchronous reset.
*/
// Register access over AXI4-Lite was chosen for this implementation.
// Functional notes
// - control bit 7 picks internal prescaled shift clock (0) or external pin (1).
// - edge bit 4 clear: transmit changes on falling, receive samples on rising.
// - edge bit 4 set: transmit changes on rising, receive samples on falling.
// - writing 1 to bit 3 clears the 3-bit counter and starts shifting.
// - bit 2 set lets the shifter and shift clock counter run.
// - bit 2 clear holds shifter and counter still, no bits move.
// - interrupt request leaves the block only while enable bit 1 is set.
// - bit 0 reads 0 with nothing pending; writing 0 clears pending.
// - bit 0 reads 1 while pending and stays set until software writes 0.
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_core
  import ssp_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`SSP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`SSP_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`SSP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [`SSP_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   sck_i,
  output logic                        sck_o,
  output logic                        sck_oe_n,
  input  wire logic                   sdi_i,
  output logic                        sdo_o,
  output logic                        irq_o
);

  ssp_ctrl_t                ctrl_q;
  ssp_stat_t                stat;
  ssp_state_t               state_q;
  logic [`SSP_ADDR_W-1:0]   waddr;
  logic [`SSP_ADDR_W-1:0]   raddr;
  logic                     wr_en;
  logic                     wr_ctrl;
  logic                     wr_data;
  logic                     wr_hit;
  logic                     rd_en;
  logic                     rd_hit;
  logic [`SSP_BYTE_W-1:0]   rd_byte;
  ssp_ctrl_t                wctrl;
  logic                     start;
  logic                     pend_clr;
  logic                     done;
  logic                     busy;
  logic                     run;
  logic                     fifo_in_ready;
  logic [`SSP_BYTE_W-1:0]   fifo_data;
  logic                     fifo_valid;
  logic                     fifo_pop;
  logic                     sck_m_q;
  logic                     sck_s_q;
  logic                     sdi_m_q;
  logic                     sdi_s_q;
  logic                     sck_int_q;
  logic [`SSP_PRE_W-1:0]    pre_q;
  logic                     lvl;
  logic                     lvl_prev_q;
  logic                     rise;
  logic                     fall;
  logic                     tx_edge;
  logic                     rx_edge;
  logic [2:0]               cnt_q;
  logic [`SSP_BYTE_W-1:0]   tx_sr_q;
  logic [`SSP_BYTE_W-1:0]   rx_sr_q;
  logic [`SSP_BYTE_W-1:0]   rx_byte_q;
  logic                     sdo_q;

  // write address and data are taken together; a full fifo stalls data writes
  assign waddr         = {s_axi_awaddr[`SSP_ADDR_W-1:2], 2'b00};
  assign wr_data       = (waddr == `SSP_OFS_DATA);
  assign wr_ctrl       = (waddr == `SSP_OFS_CTRL);
  assign wr_hit        = wr_ctrl || wr_data;
  assign wr_en         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                         && (!wr_data || fifo_in_ready);
  assign s_axi_awready = wr_en;
  assign s_axi_wready  = wr_en;
  assign wctrl         = ssp_ctrl_t'(s_axi_wdata[`SSP_BYTE_W-1:0]);

  // only the low byte lane carries register bits
  assign start    = wr_en && wr_ctrl && s_axi_wstrb[0] && wctrl.start;
  assign pend_clr = wr_en && wr_ctrl && s_axi_wstrb[0] && !wctrl.pend;

  // write response, one cycle after the pair is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SSP_RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `SSP_RESP_OKAY : `SSP_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read decode; the start bit always reads back as zero
  assign raddr         = {s_axi_araddr[`SSP_ADDR_W-1:2], 2'b00};
  assign rd_en         = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_en;
  assign stat          = '{busy: busy, tx_full: !fifo_in_ready, tx_empty: !fifo_valid,
                           pad: `SSP_STAT_PAD, cnt: cnt_q};
  always_comb begin
    rd_byte = '0;
    rd_hit  = 1'b1;
    case (raddr)
      `SSP_OFS_CTRL: rd_byte = ctrl_q;
      `SSP_OFS_DATA: rd_byte = rx_byte_q;
      `SSP_OFS_STAT: rd_byte = stat;
      default:       rd_hit  = 1'b0;
    endcase
  end

  // read answer, registered, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `SSP_RESP_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {{(`SSP_DATA_W-`SSP_BYTE_W){1'b0}}, rd_byte};
      s_axi_rresp  <= rd_hit ? `SSP_RESP_OKAY : `SSP_RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // control register; pending is set by hardware, set wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ssp_ctrl_t'(`SSP_CTRL_RST);
    end else begin
      if (wr_en && wr_ctrl && s_axi_wstrb[0]) begin
        ctrl_q          <= wctrl;
        ctrl_q.start    <= 1'b0;
      end
      ctrl_q.pend <= done || (ctrl_q.pend && !pend_clr);
    end
  end

  // request gated by the enable bit
  assign irq_o = ctrl_q.pend && ctrl_q.int_en;

  // tx byte buffer between the bus and the shifter
  ssp_fifo #(
    .WIDTH (`SSP_BYTE_W),
    .DEPTH (`SSP_FIFO_DEPTH)
  ) u_tx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (s_axi_wdata[`SSP_BYTE_W-1:0]),
    .in_valid  (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && wr_data),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // a byte leaves the fifo only when a transmit transfer starts
  assign fifo_pop = start && wctrl.tx_rx && fifo_valid;

  // pin synchronisers, two flops each before any logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end else begin
      sck_m_q <= sck_i;
      sck_s_q <= sck_m_q;
      sdi_m_q <= sdi_i;
      sdi_s_q <= sdi_m_q;
    end
  end

  assign busy = (state_q == st_shift);
  assign run  = busy && ctrl_q.shift_en;

  // transfer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= st_idle;
    end else begin
      case (state_q)
        st_idle:  state_q <= start ? st_shift : st_idle;
        st_shift: state_q <= start ? st_shift : (done ? st_idle : st_shift);
        default:  state_q <= st_idle;
      endcase
    end
  end

  // internal shift clock; idles at the level where the first edge is a tx edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q     <= '0;
      sck_int_q <= 1'b1;
    end else if (start || !run || ctrl_q.clk_ext) begin
      pre_q     <= '0;
      sck_int_q <= start ? !wctrl.edge_rise : !ctrl_q.edge_rise;
    end else if (pre_q == `SSP_PRE_W'(`SSP_SCK_HALF_CYC - 1)) begin
      pre_q     <= '0;
      sck_int_q <= !sck_int_q;
    end else begin
      pre_q     <= pre_q + 1'b1;
    end
  end

  // the pin is driven only when the clock is made here
  assign sck_o    = sck_int_q;
  assign sck_oe_n = ctrl_q.clk_ext;

  // clock source selection and edge detection
  assign lvl = ctrl_q.clk_ext ? sck_s_q : sck_int_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_prev_q <= 1'b1;
    end else begin
      lvl_prev_q <= lvl;
    end
  end
  assign rise    = lvl && !lvl_prev_q;
  assign fall    = !lvl && lvl_prev_q;
  assign tx_edge = run && !start && (ctrl_q.edge_rise ? rise : fall);
  assign rx_edge = run && !start && (ctrl_q.edge_rise ? fall : rise);
  assign done    = rx_edge && (cnt_q == `SSP_CNT_LAST);

  // 3-bit counter of sampled bits, cleared by a start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= `SSP_CNT_ZERO;
    end else if (start) begin
      cnt_q <= `SSP_CNT_ZERO;
    end else if (rx_edge) begin
      cnt_q <= cnt_q + `SSP_CNT_ONE;
    end
  end

  // transmit shifter; an empty fifo sends all ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sr_q <= `SSP_SHIFT_RST;
      sdo_q   <= 1'b1;
    end else if (start) begin
      tx_sr_q <= fifo_pop ? fifo_data : `SSP_TX_FILL;
    end else if (tx_edge && ctrl_q.tx_rx) begin
      sdo_q   <= ctrl_q.lsb_first ? tx_sr_q[0] : tx_sr_q[`SSP_BYTE_W-1];
      tx_sr_q <= ctrl_q.lsb_first ? {1'b0, tx_sr_q[`SSP_BYTE_W-1:1]}
                                  : {tx_sr_q[`SSP_BYTE_W-2:0], 1'b0};
    end
  end
  assign sdo_o = sdo_q;

  // receive shifter, byte latched for software when the eighth bit lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sr_q   <= `SSP_SHIFT_RST;
      rx_byte_q <= `SSP_SHIFT_RST;
    end else if (rx_edge) begin
      rx_sr_q <= ctrl_q.lsb_first ? {sdi_s_q, rx_sr_q[`SSP_BYTE_W-1:1]}
                                  : {rx_sr_q[`SSP_BYTE_W-2:0], sdi_s_q};
      if (done) begin
        rx_byte_q <= ctrl_q.lsb_first ? {sdi_s_q, rx_sr_q[`SSP_BYTE_W-1:1]}
                                      : {rx_sr_q[`SSP_BYTE_W-2:0], sdi_s_q};
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  clk_source_a: assert property (ctrl_q.clk_ext |-> sck_oe_n && lvl == sck_s_q)
    else $error("external clock mode drives the clock pin");
  // edge checks watch the detector itself, so a swapped edge select
  // shows up on the first bit rather than as a corrupted byte later
  tx_fall_a: assert property (tx_edge && !ctrl_q.edge_rise |-> lvl_prev_q && !lvl)
    else $error("tx edge not falling");
  rx_rise_a: assert property (rx_edge && !ctrl_q.edge_rise |-> !lvl_prev_q && lvl)
    else $error("rx edge not rising");
  rx_fall_a: assert property (rx_edge && ctrl_q.edge_rise |-> lvl_prev_q && !lvl)
    else $error("rx edge not falling");
  tx_rise_a: assert property (tx_edge && ctrl_q.edge_rise |-> !lvl_prev_q && lvl)
    else $error("tx edge not rising");
  // counter and shifters; edges seen while frozen are lost on purpose
  start_clear_a: assert property (start |=> cnt_q == `SSP_CNT_ZERO && busy)
    else $error("start did not clear counter");
  run_count_a: assert property (rx_edge && cnt_q != `SSP_CNT_LAST |=>
                                cnt_q == $past(cnt_q) + `SSP_CNT_ONE)
    else $error("counter missed a sample");
  hold_off_a: assert property (!ctrl_q.shift_en && !start |=>
                               $stable(cnt_q) && $stable(rx_sr_q) && $stable(sdo_o))
    else $error("shifter moved while disabled");
  // pending flag: a hardware set beats a clear in the same cycle,
  // so software never loses the end of a byte it has not yet seen
  irq_gate_a: assert property (!ctrl_q.int_en |-> !irq_o)
    else $error("request leaked while disabled");
  pend_clear_a: assert property (pend_clr && !done |=> !ctrl_q.pend)
    else $error("pending not cleared by write of zero");
  pend_hold_a: assert property (ctrl_q.pend && !pend_clr |=> ctrl_q.pend)
    else $error("pending dropped without clear");
  pend_set_a: assert property (done |=> ctrl_q.pend && !busy)
    else $error("finished transfer not flagged");
  pend_read_a: assert property (rd_en && raddr == `SSP_OFS_CTRL |=>
                                s_axi_rdata[0] == $past(ctrl_q.pend))
    else $error("pending bit read back wrong");
  // bit order, both ends of the receive shifter
  lsb_order_a: assert property (rx_edge && ctrl_q.lsb_first |=>
                                rx_sr_q[`SSP_BYTE_W-1] == $past(sdi_s_q))
    else $error("lsb first sample misplaced");
  msb_order_a: assert property (rx_edge && !ctrl_q.lsb_first |=>
                                rx_sr_q[0] == $past(sdi_s_q))
    else $error("msb first sample misplaced");
  rx_only_a: assert property (!ctrl_q.tx_rx |=> $stable(sdo_o))
    else $error("output line moved in receive-only mode");

  int_done_c: cover property (done && !ctrl_q.clk_ext);
  ext_done_c: cover property (done && ctrl_q.clk_ext);
  fifo_full_c: cover property (!fifo_in_ready ##1 fifo_pop);
  set_clear_c: cover property (done && pend_clr);
  freeze_resume_c: cover property (busy && !ctrl_q.shift_en ##1 run);

endmodule : ssp_core

// ---- test/ssp_peer.sv ----
/*
  behavioural far-side serial device: shifts one byte out and one in per frame.
  assumes the bench resolves the clock pin and pulses arm before each frame.
*/
`timescale 1ns/1ps

module ssp_peer #(
  parameter int HALF = 6
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       sck_w,
  input  wire logic       sdo,
  input  wire logic       arm,
  input  wire logic       go,
  input  wire logic       edge_rise,
  input  wire logic       lsb_first,
  input  wire logic [7:0] tx_byte,
  output logic            sck_drv,
  output logic            sdi,
  output logic [7:0]      rx_byte
);
  logic       sck_d;
  logic [4:0] edges;
  logic [4:0] gen_n;
  logic [3:0] hc;
  logic [3:0] quiet;
  logic [7:0] sh;

  // clock maker for external mode, data on tx edges, capture on rx edges
  always_ff @(posedge aclk) begin
    sck_d <= sck_w;
    if (!aresetn) begin
      quiet <= 4'h0;
      edges <= 5'h10;
      gen_n <= 5'h00;
      hc <= 4'h0;
      sck_drv <= 1'b1;
      sdi <= 1'b0;
      rx_byte <= 8'h00;
      sh <= 8'h00;
    end else if (arm) begin
      edges <= 5'h00;
      sh <= tx_byte;
    end else begin
      quiet <= (sck_w != sck_d) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
      // clock stands at idle level between frames
      if (go) begin
        gen_n <= 5'h10;
        hc <= 4'h0;
      end else if (gen_n == 5'h00) begin
        sck_drv <= !edge_rise;
      end else if (hc == 4'(HALF - 1)) begin
        hc <= 4'h0;
        gen_n <= gen_n - 5'h01;
        sck_drv <= ~sck_drv;
      end else begin
        hc <= hc + 4'h1;
      end
      if (sck_w != sck_d && edges != 5'h10) begin
        edges <= edges + 5'h01;
        if (sck_w == edge_rise) begin
          sdi <= lsb_first ? sh[0] : sh[7];
          sh <= lsb_first ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
        end else begin
          rx_byte <= lsb_first ? {sdo, rx_byte[7:1]} : {rx_byte[6:0], sdo};
        end
      end else if (edges == 5'h00 || quiet == 4'hf) begin
        sdi <= ~sdi; // undriven line: never a stale bit
      end
    end
  end
endmodule : ssp_peer

// ---- test/test_sync_serial_io_control.sv ----
/*
  self-checking bench of the serial port core: register rows, transfer rows,
  frozen shifter and a full buffer. assumes the peer model answers on the pins.
*/
`timescale 1ns/1ps
`include "ssp_defs.svh"

module test_sync_serial_io_control;
  import ssp_pkg::*;

  localparam logic [7:0] CTRL = `SSP_OFS_CTRL;
  localparam logic [7:0] DATA = `SSP_OFS_DATA;
  localparam logic [7:0] STAT = `SSP_OFS_STAT;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [1:0] wresp;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ssp_reg_row_t;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] txb;
    logic [7:0] pb;
  } ssp_xfer_row_t;

  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        sck_o, sck_oe_n, sdi_i, sdo_o, irq_o, sck_drv;
  wire logic   sck_w;
  logic        arm           = 1'b0;
  logic        go            = 1'b0;
  logic [7:0]  peer_cfg      = 8'h00;
  logic [7:0]  peer_tx       = 8'h00;
  logic [7:0]  peer_rx;
  logic [31:0] rdat;
  logic [1:0]  rrsp, wrsp;
  logic [7:0]  ep;
  int          err_total     = 0;
  int          total_checks  = 0;

  ssp_reg_row_t reg_rows [4] = '{'{8'he0, 8'h72, 2'h0, 8'h72, 2'h0},
    '{8'he0, 8'h81, 2'h0, 8'h80, 2'h0}, '{8'he0, 8'h00, 2'h0, 8'h00, 2'h0},
    '{8'hf0, 8'h5a, 2'h3, 8'h00, 2'h3}};
  ssp_xfer_row_t xfer_rows [5] = '{'{8'h26, 8'ha5, 8'h3c}, '{8'h74, 8'h1e, 8'h4d},
    '{8'h06, 8'h00, 8'h6b}, '{8'ha6, 8'hc4, 8'h2d}, '{8'hf4, 8'h39, 8'h71}};

  // pin low on oe means the core drives the clock line
  assign sck_w = sck_oe_n ? sck_drv : sck_o;

  ssp_core dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_i(sck_w), .sck_o, .sck_oe_n,
    .sdi_i, .sdo_o, .irq_o
  );
  ssp_peer #(.HALF(6)) peer (
    .aclk, .aresetn, .sck_w, .sdo(sdo_o), .arm, .go, .edge_rise(peer_cfg[4]),
    .lsb_first(peer_cfg[6]), .tx_byte(peer_tx), .sck_drv, .sdi(sdi_i), .rx_byte(peer_rx)
  );

  always #5 aclk = ~aclk;

  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic tk;
    tk = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!tk && s_axi_awready === 1'b1 && s_axi_wready === 1'b1) begin
        tk = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
      end else if (tk && s_axi_bvalid === 1'b1) begin
        wrsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic tk;
    tk = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!tk && s_axi_arready === 1'b1) begin
        tk = 1'b1;
        s_axi_arvalid <= 1'b0;
      end else if (tk && s_axi_rvalid === 1'b1) begin
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  // settle idle clock level first, then arm the peer, then start
  task automatic start_x(input logic [7:0] cfg, input logic [7:0] pb);
    peer_cfg <= cfg;
    peer_tx <= pb;
    wr(CTRL, cfg);
    repeat (3) @(posedge aclk);
    arm <= 1'b1;
    @(posedge aclk);
    arm <= 1'b0;
    wr(CTRL, cfg | 8'h08);
    go <= cfg[7];
    @(posedge aclk);
    go <= 1'b0;
  endtask : start_x

  task automatic end_x(input logic [7:0] cfg, input logic [7:0] pb, input logic [7:0] ex);
    rdat = 32'h0;
    while (rdat[0] !== 1'b1) rd(CTRL);
    chk("control pending", {24'h0, cfg | 8'h01}, rdat);
    chk("irq pending", {31'h0, cfg[1]}, {31'h0, irq_o});
    chk("clock enable", {31'h0, cfg[7]}, {31'h0, sck_oe_n});
    rd(DATA);
    chk("rx byte", {24'h0, pb}, rdat);
    chk("peer byte", {24'h0, ex}, {24'h0, peer_rx});
    wr(CTRL, cfg);
    rd(CTRL);
    chk("control cleared", {24'h0, cfg}, rdat);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
  endtask : end_x

  // about seven times the expected run
  initial begin
    #250000;
    err_total++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("sck idle", 32'h1, {31'h0, sck_o});
    chk("sck enable", 32'h0, {31'h0, sck_oe_n});
    chk("irq reset", 32'h0, {31'h0, irq_o});
    rd(CTRL);
    chk("control reset", 32'h0, rdat);
    rd(STAT);
    chk("status reset", 32'h20, rdat);
    foreach (reg_rows[i]) begin
      wr(reg_rows[i].addr, reg_rows[i].wdata);
      chk("write resp", {30'h0, reg_rows[i].wresp}, {30'h0, wrsp});
      rd(reg_rows[i].addr);
      chk("read data", {24'h0, reg_rows[i].rdata}, rdat);
      chk("read resp", {30'h0, reg_rows[i].rresp}, {30'h0, rrsp});
    end
    foreach (xfer_rows[i]) begin
      ep = xfer_rows[i].cfg[5] ? xfer_rows[i].txb : {8{sdo_o}};
      if (xfer_rows[i].cfg[5]) wr(DATA, xfer_rows[i].txb);
      start_x(xfer_rows[i].cfg, xfer_rows[i].pb);
      end_x(xfer_rows[i].cfg, xfer_rows[i].pb, ep);
    end
    // enable clear: counter and clock must not move, then resume
    start_x(8'h22, 8'hb7);
    repeat (40) @(posedge aclk);
    rd(STAT);
    chk("frozen status", 32'ha0, rdat);
    chk("frozen sck", 32'h1, {31'h0, sck_o});
    wr(CTRL, 8'h26);
    end_x(8'h26, 8'hb7, 8'hff);
    // buffer filled to the brim, then drained by transfers
    for (int i = 0; i < `SSP_FIFO_DEPTH; i++) wr(DATA, 8'(i * 7 + 3));
    rd(STAT);
    chk("fifo full", 32'h40, rdat & 32'he0);
    for (int i = 0; i < `SSP_FIFO_DEPTH; i++) begin
      start_x(8'h24, 8'(i));
      end_x(8'h24, 8'(i), 8'(i * 7 + 3));
    end
    rd(STAT);
    chk("fifo empty", 32'h20, rdat & 32'he0);
    stop_test();
  end
endmodule : test_sync_serial_io_control
